// ### verilog/plfd_pkg.sv
// Constants, types and field layout shared by the program label field decoder
////////////////////////////////////////////////////////////////////////////////
package plfd_pkg;

	// Received item framing and line kinds
	typedef enum logic [1:0] {TAG_START, TAG_BYTE, TAG_END_OK, TAG_END_BAD} plfd_tag_e;
	typedef enum logic [1:0] {MODE_VPS, MODE_FMT1, MODE_FMT2} plfd_mode_e;

	typedef struct packed {
		plfd_tag_e  tag;
		plfd_mode_e kind;
		logic [7:0] data;
	} plfd_item_s;

	localparam int ITEM_W      = $bits(plfd_item_s);
	localparam int FIFO_DEPTH  = 4;
	localparam int STORE_BYTES = 32;
	localparam int BNUM_W      = 6;

	// Byte numbers within a line
	localparam int B_VPS_RSVD = 5;
	localparam int B_13       = 13;
	localparam int B_14       = 14;
	localparam int B_15       = 15;
	localparam int B_16       = 16;
	localparam int B_17       = 17;
	localparam int B_18       = 18;
	localparam int B_19       = 19;
	localparam int B_20       = 20;
	localparam int B_21       = 21;
	localparam int B_22       = 22;
	localparam int B_23       = 23;
	localparam int B_24       = 24;
	localparam int B_25       = 25;
	localparam logic [BNUM_W-1:0] LAST_PKT_BYTE = 6'h19;
	localparam logic [BNUM_W-1:0] LAST_VPS_BYTE = 6'h0F;
	localparam logic [BNUM_W-1:0] FIRST_BNUM    = 6'h01;
	localparam logic [BNUM_W-1:0] BNUM_SAT      = 6'h20;

	// Message bit positions in a received byte (bit 7 is the first bit sent)
	localparam int MSG_B0 = 6;
	localparam int MSG_B1 = 4;
	localparam int MSG_B2 = 2;
	localparam int MSG_B3 = 0;

	// Register map
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] REG_CTRL      = 12'h000;
	localparam logic [ADDR_W-1:0] REG_STATUS    = 12'h004;
	localparam logic [ADDR_W-1:0] REG_F1_NET    = 12'h008;
	localparam logic [ADDR_W-1:0] REG_F1_DATE   = 12'h00C;
	localparam logic [ADDR_W-1:0] REG_F1_UTC    = 12'h010;
	localparam logic [ADDR_W-1:0] REG_F1_LABEL  = 12'h014;
	localparam logic [ADDR_W-1:0] REG_F2_CTRL   = 12'h018;
	localparam logic [ADDR_W-1:0] REG_F2_CNI    = 12'h01C;
	localparam logic [ADDR_W-1:0] REG_F2_PIL    = 12'h020;
	localparam logic [ADDR_W-1:0] REG_F2_PTY    = 12'h024;
	localparam logic [ADDR_W-1:0] REG_VPS_RSVD  = 12'h028;
	localparam logic [ADDR_W-1:0] REG_RAW_BASE  = 12'h080;
	localparam logic [ADDR_W-1:0] REG_RAW_MASK  = 12'hF80;
	localparam logic [1:0]        CTRL_MODE_RST = 2'h0;
	localparam logic [1:0]        RESP_OKAY     = 2'h0;
	localparam logic [1:0]        RESP_SLVERR   = 2'h2;

endpackage

// ### verilog/plfd_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module plfd_fifo
	import plfd_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
)(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	// Pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("plfd_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic [CW-1:0]    count_next;
	logic             ready_reg;
	wire              push = in_valid & ready_reg;
	wire              pop  = out_valid & out_ready;

	// Ready is a flop of its own so the source sees it with no gate in the path
	assign count_next = count_reg + CW'(push) - CW'(pop);
	assign in_ready   = ready_reg;
	assign out_valid  = (count_reg != '0);
	assign out_data   = mem[rd_ptr_reg];

	// Storage needs no reset; only valid entries are ever read
	always_ff @(posedge aclk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// Pointers and occupancy
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			ready_reg  <= 1'b1;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + PW'(push);
			rd_ptr_reg <= rd_ptr_reg + PW'(pop);
			count_reg  <= count_next;
			ready_reg  <= (count_next != CNT_FULL);
		end
	end
endmodule

// ### verilog/plfd_byte_store.sv
// Shadow and host-visible byte stores, swapped in as a whole set on commit
`timescale 1ns/10ps
module plfd_byte_store
	import plfd_pkg::*;
#(
	parameter int NBYTES = 32
)(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic                      wr_en,
	input  wire logic [$clog2(NBYTES)-1:0] wr_idx,
	input  wire logic [7:0]                wr_data,
	input  wire logic                      commit,
	output logic [NBYTES*8-1:0]            live_flat
);
	// Packet fields reach up to byte 25
	if (NBYTES < 26)
	begin : g_bad_size
		$error("plfd_byte_store needs room for byte 25");
	end

	logic [7:0] shadow [NBYTES];
	logic [7:0] live   [NBYTES];

	// Incoming line fills the shadow; the host never sees a half line
	always_ff @(posedge aclk)
	begin
		if (wr_en)
			shadow[wr_idx] <= wr_data;
	end

	// Whole-set copy keeps every field of one line consistent
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			live <= '{default: 8'h00};
		else if (commit)
			live <= shadow;
	end

	for (genvar i = 0; i < NBYTES; i++)
	begin : g_flat
		assign live_flat[i*8 +: 8] = live[i];
	end
endmodule

// ### verilog/plfd_decoder.sv
// Label field decoder: line capture, field layout and AXI4-Lite register slave
`timescale 1ns/10ps
module plfd_decoder
	import plfd_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              rx_valid,
	output logic                   rx_ready,
	input  wire plfd_item_s        rx_item,
	input  wire logic              field_start,
	output logic                   data_valid_n
);
	localparam int IDX_W = $clog2(STORE_BYTES);

	////////////////////////////////////////////////////////////////////////////
	// Receive buffer and line capture

	logic                     f_valid;
	logic                     f_ready;
	logic [ITEM_W-1:0]        f_data;
	plfd_item_s               item;
	logic [STORE_BYTES*8-1:0] live_flat;
	logic [1:0]               mode_reg;
	logic [BNUM_W-1:0]        bnum_reg;
	logic [1:0]               line_kind_reg;
	logic                     in_line_reg;
	logic                     commit_reg;
	logic                     data_valid_n_reg;
	logic [7:0]               commit_cnt_reg;

	plfd_fifo #(
		.WIDTH (ITEM_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.in_data   (rx_item),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	// Drain stalls for the commit cycle so a new line cannot overtake the swap
	assign item      = plfd_item_s'(f_data);
	assign f_ready   = ~commit_reg;
	wire pop         = f_valid & f_ready;
	wire pop_start   = pop & (item.tag == TAG_START);
	wire pop_byte    = pop & (item.tag == TAG_BYTE);
	wire pop_end_ok  = pop & (item.tag == TAG_END_OK);
	wire pop_end     = pop & (item.tag inside {TAG_END_OK, TAG_END_BAD});
	wire kind_match  = in_line_reg & (line_kind_reg == mode_reg);
	wire [BNUM_W-1:0] last_need = (mode_reg == MODE_VPS) ? LAST_VPS_BYTE : LAST_PKT_BYTE;
	wire store_wr    = pop_byte & kind_match & (bnum_reg != BNUM_SAT);
	wire commit_next = pop_end_ok & kind_match & (bnum_reg > last_need);
	wire [BNUM_W-1:0] bnum_inc = (bnum_reg == BNUM_SAT) ? bnum_reg : bnum_reg + FIRST_BNUM;

	// Bytes are stored exactly as received, no bit touched
	plfd_byte_store #(
		.NBYTES (STORE_BYTES)
	) u_store (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.wr_en     (store_wr),
		.wr_idx    (bnum_reg[IDX_W-1:0]),
		.wr_data   (item.data),
		.commit    (commit_reg),
		.live_flat (live_flat)
	);

	// Line tracking; byte numbers count from one at the line start
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bnum_reg      <= FIRST_BNUM;
			line_kind_reg <= MODE_VPS;
			in_line_reg   <= 1'b0;
			commit_reg    <= 1'b0;
		end
		else
		begin
			commit_reg <= commit_next;
			if (pop_start)
			begin
				bnum_reg      <= FIRST_BNUM;
				line_kind_reg <= item.kind;
				in_line_reg   <= 1'b1;
			end
			else if (pop_byte)
				bnum_reg <= bnum_inc;
			else if (pop_end)
				in_line_reg <= 1'b0;
		end
	end

	// Valid flag: commit pulls it low, the next field start releases it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			data_valid_n_reg <= 1'b1;
			commit_cnt_reg   <= 8'h00;
		end
		else if (commit_reg)
		begin
			data_valid_n_reg <= 1'b0;
			commit_cnt_reg   <= commit_cnt_reg + 8'h01;
		end
		else if (field_start)
			data_valid_n_reg <= 1'b1;
	end
	assign data_valid_n = data_valid_n_reg;

	////////////////////////////////////////////////////////////////////////////
	// Field layout

	function automatic logic [7:0] byte_at(input logic [STORE_BYTES*8-1:0] v, input int n);
		return v[n*8 +: 8];
	endfunction

	// Message nibble, bit 3 holds message bit 0 so fields concatenate b0 first
	function automatic logic [3:0] nib_at(input logic [STORE_BYTES*8-1:0] v, input int n);
		logic [7:0] b;
		b = v[n*8 +: 8];
		return {b[MSG_B0], b[MSG_B1], b[MSG_B2], b[MSG_B3]};
	endfunction

	// Format 1 fields: plain byte groups, digits left offset and bit order as sent
	wire [31:0] f1_net_w   = {8'h00, byte_at(live_flat, B_13), byte_at(live_flat, B_14),
		byte_at(live_flat, B_15)};
	wire [31:0] f1_date_w  = {8'h00, byte_at(live_flat, B_16), byte_at(live_flat, B_17),
		byte_at(live_flat, B_18)};
	wire [31:0] f1_utc_w   = {8'h00, byte_at(live_flat, B_19), byte_at(live_flat, B_20),
		byte_at(live_flat, B_21)};
	wire [31:0] f1_label_w = {byte_at(live_flat, B_22), byte_at(live_flat, B_23),
		byte_at(live_flat, B_24), byte_at(live_flat, B_25)};

	// Format 2 nibbles, one per byte from byte 13 on
	wire [3:0] n13 = nib_at(live_flat, B_13);
	wire [3:0] n14 = nib_at(live_flat, B_14);
	wire [3:0] n15 = nib_at(live_flat, B_15);
	wire [3:0] n16 = nib_at(live_flat, B_16);
	wire [3:0] n17 = nib_at(live_flat, B_17);
	wire [3:0] n18 = nib_at(live_flat, B_18);
	wire [3:0] n19 = nib_at(live_flat, B_19);
	wire [3:0] n20 = nib_at(live_flat, B_20);
	wire [3:0] n21 = nib_at(live_flat, B_21);
	wire [3:0] n22 = nib_at(live_flat, B_22);
	wire [3:0] n23 = nib_at(live_flat, B_23);
	wire [3:0] n24 = nib_at(live_flat, B_24);
	wire [3:0] n25 = nib_at(live_flat, B_25);

	// Channel id, update flag, sound status; reserved bits ride along as sent
	wire [1:0]  label_channel_id       = n13[3:2];
	wire        label_update_flag      = n13[1];
	wire [1:0]  program_control_status = n14[3:2];
	wire [31:0] f2_ctrl_w = {24'h000000, n14[1:0], program_control_status, n13[0],
		label_update_flag, label_channel_id};
	wire [19:0] program_ident_label = {n16[1:0], n17, n18, n19, n20, n21[3:2]};
	wire [15:0] country_network_code = {n15, n21[1:0], n22[3:2], n16[3:2], n22[1:0],
		n23};
	wire [7:0]  program_type_code = {n24, n25};

	// Status: valid flag, line in progress, count of complete sets
	wire [31:0] status_w = {16'h0000, commit_cnt_reg, 6'h00, in_line_reg, ~data_valid_n_reg};

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	wire [ADDR_W-1:0] ra        = {s_axi_araddr[ADDR_W-1:2], 2'b00};
	wire              ra_raw    = (ra & REG_RAW_MASK) == REG_RAW_BASE;
	wire [IDX_W-1:0]  ra_idx    = ra[IDX_W+1:2];
	wire [31:0]       raw_w     = {24'h000000, live_flat[ra_idx*8 +: 8]};
	wire [31:0]       vps_rsv_w = {24'h000000, byte_at(live_flat, B_VPS_RSVD)};
	logic [31:0] rd_mux;
	logic        rd_hit;

	// Register select
	always_comb
	begin
		rd_hit = 1'b1;
		rd_mux = 32'h00000000;
		if (ra_raw)
			rd_mux = raw_w;
		else
		begin
			unique case (ra)
				REG_CTRL:     rd_mux = {30'h00000000, mode_reg};
				REG_STATUS:   rd_mux = status_w;
				REG_F1_NET:   rd_mux = f1_net_w;
				REG_F1_DATE:  rd_mux = f1_date_w;
				REG_F1_UTC:   rd_mux = f1_utc_w;
				REG_F1_LABEL: rd_mux = f1_label_w;
				REG_F2_CTRL:  rd_mux = f2_ctrl_w;
				REG_F2_CNI:   rd_mux = {16'h0000, country_network_code};
				REG_F2_PIL:   rd_mux = {12'h000, program_ident_label};
				REG_F2_PTY:   rd_mux = {24'h000000, program_type_code};
				REG_VPS_RSVD: rd_mux = vps_rsv_w;
				default:      rd_hit = 1'b0;
			endcase
		end
	end

	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	wire ar_hs = s_axi_arvalid & arready_reg;

	// One read at a time, answered the cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h00000000;
			rresp_reg   <= RESP_OKAY;
		end
		else if (ar_hs)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_mux;
			rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path

	logic awready_reg;
	logic wready_reg;
	logic aw_got_reg;
	logic w_got_reg;
	logic bvalid_reg;
	logic [1:0]        bresp_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	wire  [ADDR_W-1:0] wa       = {awaddr_reg[ADDR_W-1:2], 2'b00};
	wire  wr_do     = aw_got_reg & w_got_reg & ~bvalid_reg;
	wire  wr_ctrl   = wr_do & (wa == REG_CTRL) & wstrb_reg[0];
	wire  wa_known  = (wa <= REG_VPS_RSVD) || ((wa & REG_RAW_MASK) == REG_RAW_BASE);

	// Address and data are taken in either order; the answer follows both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			awaddr_reg  <= '0;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && awready_reg)
			begin
				awready_reg <= 1'b0;
				aw_got_reg  <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_reg)
			begin
				wready_reg <= 1'b0;
				w_got_reg  <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_do)
			begin
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg  <= wa_known ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready)
			begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// Mode selects which line kind is captured; other registers are read only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_reg <= CTRL_MODE_RST;
		else if (wr_ctrl)
			mode_reg <= wdata_reg[1:0];
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	logic [7:0] seen13_reg;

	// Byte 13 of the line under capture, for the pass-through check
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			seen13_reg <= 8'h00;
		else if (store_wr && bnum_reg == BNUM_W'(B_13))
			seen13_reg <= item.data;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_good_end;
		pop_end_ok && kind_match && (bnum_reg > last_need);
	endsequence
	sequence s_commit_done;
		commit_reg ##1 !data_valid_n;
	endsequence
	sequence s_pil_read;
		ar_hs && (ra == REG_F2_PIL);
	endsequence

	commit_sets_valid_a: assert property (s_good_end |=> s_commit_done)
		else $error("valid set did not pull data_valid_n low");
	set_held_a: assert property (!commit_reg |=> $stable(live_flat))
		else $error("captured bytes changed without a commit");
	mismatch_no_store_a: assert property (pop_end_ok && !kind_match |=> !commit_reg)
		else $error("line of another mode was committed");
	net_passthru_a: assert property (commit_reg |=> byte_at(live_flat, B_13) == $past(seen13_reg))
		else $error("network byte altered on its way to the host");
	pil_read_a: assert property (s_pil_read |=> s_axi_rvalid &&
		s_axi_rdata[19:0] == $past(program_ident_label))
		else $error("ident label read does not match captured bits");
	ctrl_rsvd_a: assert property (ar_hs && ra == REG_F2_CTRL |=> s_axi_rvalid &&
		s_axi_rdata[3] == $past(live_flat[B_13*8 + MSG_B3]))
		else $error("reserved message bit not passed through");
	valid_release_a: assert property (field_start && !commit_reg |=> data_valid_n ##1
		(data_valid_n || $past(commit_reg)))
		else $error("data_valid_n not released at field start");
	write_answer_a: assert property (aw_got_reg && w_got_reg && !bvalid_reg |=> bvalid_reg
		##0 !aw_got_reg)
		else $error("write answer did not follow address and data");
	vps_rsvd_a: assert property (ar_hs && ra == REG_VPS_RSVD |=>
		s_axi_rdata[7:0] == $past(byte_at(live_flat, B_VPS_RSVD)))
		else $error("reserved video line byte not shown apart");
endmodule

// ### tb/plfd_line_src.sv
// Receiver model that offers framed lines on the byte stream
`timescale 1ns/10ps
module plfd_line_src
	import plfd_pkg::*;
(
	input  wire logic  aclk,
	input  wire logic  rx_ready,
	output logic       rx_valid,
	output plfd_item_s rx_item
);
	logic [7:0] lb [1:31];
	int         stall_count;

	initial
	begin
		rx_valid = 1'b0;
		rx_item = '0;
		stall_count = 0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hold each item until taken or 100 cycles pass; an idle bus shows the inverse so stale data never looks valid
	task put(input plfd_item_s it, input int gap);
		int n;
		begin
			rx_valid <= 1'b1;
			rx_item <= it;
			for (n = 0; n < 100; n++)
			begin
				@(posedge aclk);
				if (rx_ready)
					break;
			end
			if (n == 100)
				stall_count++;
			if (gap > 0)
			begin
				rx_valid <= 1'b0;
				rx_item <= plfd_item_s'(~it);
				repeat (gap) @(posedge aclk);
			end
		end
	endtask

	// One line: start mark, bytes numbered from 1, closing mark
	task send_line(input plfd_mode_e k, input int nb, input logic ok, input int gap);
		int j;
		begin
			put(plfd_item_s'{TAG_START, k, 8'h00}, gap);
			for (j = 1; j <= nb; j++)
				put(plfd_item_s'{TAG_BYTE, k, lb[j]}, gap);
			put(plfd_item_s'{ok ? TAG_END_OK : TAG_END_BAD, k, 8'h00}, gap);
			if (gap == 0)
			begin
				rx_valid <= 1'b0;
				rx_item <= plfd_item_s'(~rx_item);
			end
		end
	endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the label field decoder
`timescale 1ns/10ps
module testbench
	import plfd_pkg::*;
;
	typedef struct packed {logic [31:0] e; logic [31:0] m; logic [1:0] r;} plfd_tb_exp_s;
	logic              aclk, aresetn, field_start, data_valid_n;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, rx_valid, rx_ready;
	plfd_item_s        rx_item;
	int                err_count, check_count, seed, i;
	logic [7:0]        b [1:31];
	logic [0:51]       mb;
	plfd_tb_exp_s      exp_q[$];
	logic [1:0]        bexp_q[$];
	logic [7:0]        ob [1:31];
	logic [31:0]       cni_e;

	plfd_decoder dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_item(rx_item), .field_start(field_start), .data_valid_n(data_valid_n));
	plfd_line_src src_u (.aclk(aclk), .rx_ready(rx_ready), .rx_valid(rx_valid),
		.rx_item(rx_item));

	initial
		aclk = 1'b0;
	always #2.5 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////////
	// Reporting and comparisons
	task results;
		begin
			if (src_u.stall_count != 0)
				miss("line source stalled");
			$display("errors %0d checks %0d", err_count, check_count);
			if (err_count == 0 && check_count > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task miss(input string s);
		begin
			err_count++;
			$display("MISMATCH %0t %s", $time, s);
		end
	endtask
	task hang(input string s);
		begin
			miss(s);
			results;
		end
	endtask
	task chk_w(input plfd_tb_exp_s x, input logic [31:0] d, input logic [1:0] r);
		begin
			check_count++;
			if (((d & x.m) !== (x.e & x.m)) || (r !== x.r))
				miss("read word");
		end
	endtask
	task chk_b(input logic [1:0] e, input logic [1:0] g);
		begin
			check_count++;
			if (g !== e)
				miss("flag or response");
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite master; each task ends one edge after its handshake so nothing is driven twice
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bexp_q.push_back(r);
			bready <= 1'b1;
			for (i = 0; i < 60; i++)
			begin
				@(posedge aclk);
				if (awready)
					awvalid <= 1'b0;
				if (wready)
					wvalid <= 1'b0;
				if (bvalid)
					break;
			end
			bready <= 1'b0;
			if (i == 60)
				hang("write hang");
			@(posedge aclk);
		end
	endtask
	task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] r);
		begin
			exp_q.push_back(plfd_tb_exp_s'{e, m, r});
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			for (i = 0; i < 60; i++)
			begin
				@(posedge aclk);
				if (arready)
					arvalid <= 1'b0;
				if (rvalid)
					break;
			end
			rready <= 1'b0;
			if (i == 60)
				hang("read hang");
			@(posedge aclk);
		end
	endtask

	// Scoreboard: each read or write answer meets the oldest note of its kind
	always @(posedge aclk)
	begin
		if (rvalid && rready)
		begin
			if (exp_q.size() == 0)
				miss("unexpected read");
			else
				chk_w(exp_q.pop_front(), rdata, rresp);
		end
		if (bvalid && bready)
		begin
			if (bexp_q.size() == 0)
				miss("unexpected write answer");
			else
				chk_b(bexp_q.pop_front(), bresp);
		end
	end

	task wait_dv;
		begin
			for (i = 0; i < 300 && data_valid_n !== 1'b0; i++)
				@(posedge aclk);
			if (i == 300)
				hang("valid hang");
		end
	endtask
	task fs;
		begin
			field_start <= 1'b1;
			@(posedge aclk);
			field_start <= 1'b0;
			repeat (2) @(posedge aclk);
		end
	endtask
	task new_bytes;
		begin
			for (i = 1; i < 32; i++)
				b[i] = 8'($random(seed));
			src_u.lb = b;
		end
	endtask
	// Field value from message bits, first bit weighted highest
	function automatic logic [31:0] fld(input int s, input int n);
		logic [31:0] v;
		begin
			v = '0;
			for (int j = 0; j < n; j++)
				v = {v[30:0], mb[s+j]};
			return v;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		seed = 71553;
		err_count = 0;
		check_count = 0;
		{aresetn, field_start, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_b(2'h1, {1'b0, data_valid_n});
		rd(REG_CTRL, {30'h0, CTRL_MODE_RST}, 32'h3, RESP_OKAY);
		wr(12'h030, 32'h0, RESP_SLVERR);
		rd(12'h030, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
		wr(REG_F1_NET, 32'h5, RESP_OKAY);
		rd(REG_F1_NET, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
		$display("test reset done");
		wr(REG_CTRL, 32'h1, RESP_OKAY);
		new_bytes;
		src_u.send_line(MODE_FMT1, 25, 1'b1, 0);
		wait_dv;
		rd(REG_F1_NET, {8'h00, b[13], b[14], b[15]}, 32'hFFFFFFFF, RESP_OKAY);
		rd(REG_F1_DATE, {8'h00, b[16], b[17], b[18]}, 32'hFFFFFFFF, RESP_OKAY);
		rd(REG_F1_UTC, {8'h00, b[19], b[20], b[21]}, 32'hFFFFFFFF, RESP_OKAY);
		rd(REG_F1_LABEL, {b[22], b[23], b[24], b[25]}, 32'hFFFFFFFF, RESP_OKAY);
		rd(REG_STATUS, 32'h0101, 32'hFF01, RESP_OKAY);
		fs;
		chk_b(2'h1, {1'b0, data_valid_n});
		src_u.lb[13] = ~b[13];
		src_u.send_line(MODE_FMT1, 25, 1'b0, 1);
		src_u.send_line(MODE_FMT1, 24, 1'b1, 1);
		src_u.send_line(MODE_FMT2, 25, 1'b1, 1);
		repeat (8) @(posedge aclk);
		chk_b(2'h1, {1'b0, data_valid_n});
		rd(REG_F1_NET, {8'h00, b[13], b[14], b[15]}, 32'hFFFFFFFF, RESP_OKAY);
		$display("test format1 done");
		wr(REG_CTRL, 32'h2, RESP_OKAY);
		new_bytes;
		for (i = 13; i < 26; i++)
			mb[(i-13)*4 +: 4] = {b[i][6], b[i][4], b[i][2], b[i][0]};
		src_u.send_line(MODE_FMT2, 25, 1'b1, 2);
		wait_dv;
		rd(REG_F2_CTRL, {24'h0, mb[6], mb[7], mb[4], mb[5], mb[3], mb[2], mb[0], mb[1]},
			32'hFF, RESP_OKAY);
		cni_e = (fld(8, 4) << 12) | (fld(34, 4) << 8) | (fld(12, 2) << 6) | fld(38, 6);
		rd(REG_F2_CNI, cni_e, 32'hFFFF, RESP_OKAY);
		rd(REG_F2_PIL, fld(14, 20), 32'hFFFFF, RESP_OKAY);
		rd(REG_F2_PTY, fld(44, 8), 32'hFF, RESP_OKAY);
		rd(REG_STATUS, 32'h0201, 32'hFF01, RESP_OKAY);
		// Next label keeps every country and network bit, as a service code line must
		fs;
		ob = b;
		new_bytes;
		b[15] = ob[15];
		b[22] = ob[22];
		b[23] = ob[23];
		b[16][6] = ob[16][6];
		b[16][4] = ob[16][4];
		b[21][2] = ob[21][2];
		b[21][0] = ob[21][0];
		src_u.lb = b;
		for (i = 13; i < 26; i++)
			mb[(i-13)*4 +: 4] = {b[i][6], b[i][4], b[i][2], b[i][0]};
		src_u.send_line(MODE_FMT2, 25, 1'b1, 0);
		wait_dv;
		rd(REG_F2_CNI, cni_e, 32'hFFFF, RESP_OKAY);
		rd(REG_F2_PIL, fld(14, 20), 32'hFFFFF, RESP_OKAY);
		$display("test format2 done");
		wr(REG_CTRL, 32'h0, RESP_OKAY);
		fs;
		new_bytes;
		src_u.send_line(MODE_VPS, 14, 1'b1, 0);
		repeat (8) @(posedge aclk);
		chk_b(2'h1, {1'b0, data_valid_n});
		src_u.send_line(MODE_VPS, 15, 1'b1, 0);
		wait_dv;
		rd(REG_VPS_RSVD, {24'h0, b[5]}, 32'hFF, RESP_OKAY);
		rd(REG_RAW_BASE + 12'h03C, {24'h0, b[15]}, 32'hFF, RESP_OKAY);
		$display("test video line done");
		repeat (4) @(posedge aclk);
		results;
	end

	initial
	begin
		#200000;
		hang("run timeout");
	end
endmodule
